// File: rtl/adcc_pkg.sv
`default_nettype none
package adcc_pkg;

  // internal data and error arithmetic widths
  localparam int DW    = 16;
  localparam int CW    = 20;
  localparam int IDX_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CONV_CTRL      = 10'h111;
  localparam logic [IDX_W-1:0] IDX_SAMPLE_CTRL    = 10'h112;
  localparam logic [IDX_W-1:0] IDX_COMPUTE_CTRL   = 10'h113;
  localparam logic [IDX_W-1:0] IDX_THRESHOLD_CTRL = 10'h114;
  localparam logic [IDX_W-1:0] IDX_COMPUTE_STATUS = 10'h115;
  localparam logic [IDX_W-1:0] IDX_SETPOINT       = 10'h120;
  localparam logic [IDX_W-1:0] IDX_UPPER_TH       = 10'h121;
  localparam logic [IDX_W-1:0] IDX_LOWER_TH       = 10'h122;
  localparam logic [IDX_W-1:0] IDX_REPEAT         = 10'h123;
  localparam logic [IDX_W-1:0] IDX_RESULT         = 10'h124;
  localparam logic [IDX_W-1:0] IDX_PREV           = 10'h125;
  localparam logic [IDX_W-1:0] IDX_FILTER         = 10'h126;
  localparam logic [IDX_W-1:0] IDX_ERROR          = 10'h127;
  localparam logic [IDX_W-1:0] IDX_ACCUM          = 10'h128;
  localparam logic [IDX_W-1:0] IDX_COUNT          = 10'h129;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CONTINUOUS_EN_BIT     = 6;
  localparam int GO_BIT       = 0;
  localparam int DOUBLE_SAMPLE_EN_BIT     = 0;
  localparam int PSRC_BIT     = 7;
  localparam int SHIFT_LSB    = 4;
  localparam int ACCUM_CLEAR_CMD_BIT     = 3;
  localparam int MODE_LSB     = 0;
  localparam int ESEL_LSB     = 4;
  localparam int STOP_BIT     = 3;
  localparam int TMD_LSB      = 0;
  localparam int MATH_BIT     = 4;

  ////////////////////////////////////////////////////////////////////////////
  // codes
  localparam logic [2:0] MODE_BASIC = 3'h0;
  localparam logic [2:0] MODE_ACCUM = 3'h1;
  localparam logic [2:0] MODE_AVG   = 3'h2;
  localparam logic [2:0] MODE_BURST = 3'h3;
  localparam logic [2:0] MODE_LPF   = 3'h4;

  localparam logic [2:0] ESEL_DIFF     = 3'h0;
  localparam logic [2:0] ESEL_SETPT    = 3'h1;
  localparam logic [2:0] ESEL_FILT     = 3'h2;
  localparam logic [2:0] ESEL_PREV_FLT = 3'h4;
  localparam logic [2:0] ESEL_FLT_SET  = 3'h5;

  localparam logic [2:0] TMD_NEVER   = 3'h0;
  localparam logic [2:0] TMD_BELOW   = 3'h1;
  localparam logic [2:0] TMD_NOT_LOW = 3'h2;
  localparam logic [2:0] TMD_INSIDE  = 3'h3;
  localparam logic [2:0] TMD_OUTSIDE = 3'h4;
  localparam logic [2:0] TMD_NOT_UP  = 3'h5;
  localparam logic [2:0] TMD_ABOVE   = 3'h6;
  localparam logic [2:0] TMD_ALWAYS  = 3'h7;

  localparam logic [2:0] STAT_IDLE  = 3'h0;
  localparam logic [2:0] STAT_CONV1 = 3'h3;
  localparam logic [2:0] STAT_CONV2 = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_CONV1 = 6'h02,
    S_CONV2 = 6'h04,
    S_ERROR_SEL_A  = 6'h08,
    S_ERR   = 6'h10,
    S_THR   = 6'h20
  } adcc_state_t;

endpackage : adcc_pkg
`default_nettype wire

// File: rtl/adcc_top.sv
// The AXI4-Lite slave port is this design's own decision.
`default_nettype none
// Operation
// [R01] double sample: two conversions, first into previous
// [R02] conversion start copies filter or result to previous
// [R03] low-pass time constant is two to shift
// [R04] accumulating modes right-shift sum by shift
// [R05] basic mode ignores shift select
// [R06] software avoids shift value all ones
// [R07] software sets repeat target to two^shift
// [R08] clear command clears sum, overflow, count
// [R09] hardware drops clear command when done
// [R10] mode field picks basic/accum/avg/burst/lowpass
// [R11] error code 000: result minus previous
// [R12] error code 001: subtract setpoint
// [R13] error code 010: subtract filter value
// [R14] error code 100: previous minus filter
// [R15] error code 101: filter minus setpoint
// [R16] double sample difference is second minus first
// [R17] continuous with stop: clear go on hit
// [R18] continuous without stop: go never cleared here
// [R19] not continuous: stop setting ignored
// [R20] threshold mode 111 always, 000 never
// [R21] single-sided threshold compare modes
// [R22] outside and inside window threshold modes
// [R23] continuous retriggers, else go clears
// [R24] error and threshold once per trigger, last
module adcc_top
  import adcc_pkg::*;
#(
  parameter int RES_W  = 12,
  parameter int ACC_W  = 18,
  parameter int CNT_W  = 8,
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_B,
  // converter side
  input  wire logic              TRIGGER,
  input  wire logic              CONV_DONE,
  input  wire logic [RES_W-1:0]  CONV_DATA,
  output logic                   CONV_REQ,
  output logic                   CONV_BUSY,
  output logic                   THRESH_EVENT,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic signed [CW-1:0] zx(input logic [DW-1:0] v);
    return $signed({{(CW-DW){1'b0}}, v});
  endfunction : zx

  function automatic logic signed [CW-1:0] sx(input logic [DW-1:0] v);
    return $signed({{(CW-DW){v[DW-1]}}, v});
  endfunction : sx

  function automatic logic [DW-1:0] merge16(input logic [DW-1:0] old,
                                            input logic [31:0]   d,
                                            input logic [3:0]    s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic mapped(input logic [IDX_W-1:0] i);
    return (i >= IDX_CONV_CTRL && i <= IDX_COMPUTE_STATUS) ||
           (i >= IDX_SETPOINT && i <= IDX_COUNT);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  logic [ADDR_W-1:0]      awaddr_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   wr_go;
  logic [IDX_W-1:0]       wr_idx;
  logic [IDX_W-1:0]       rd_idx;
  logic [31:0]            rd_word;

  logic                   continuous_en_q;
  logic                   go_q;
  logic                   double_sample_en_q;
  logic                   prev_src_q;
  logic [2:0]             shift_q;
  logic                   accum_clear_q;
  logic [2:0]             mode_q;
  logic [2:0]             err_sel_q;
  logic                   stop_on_q;
  logic [2:0]             tmd_q;
  logic [DW-1:0]          setpoint_q;
  logic signed [DW-1:0]   uth_q;
  logic signed [DW-1:0]   lth_q;
  logic [CNT_W-1:0]       rpt_q;

  logic [DW-1:0]          result_q;
  logic [DW-1:0]          prev_q;
  logic [DW-1:0]          filter_q;
  logic signed [DW-1:0]   err_q;
  logic [ACC_W-1:0]       acc_q;
  logic [CNT_W-1:0]       cnt_q;
  logic                   ov_q;
  logic                   up_flag_q;
  logic                   lo_flag_q;
  logic                   math_q;

  adcc_state_t            state_q;
  adcc_state_t            state_d;
  logic                   start1;
  logic                   start2;
  logic                   trig_start;
  logic                   retrig;
  logic                   hit;
  logic                   up_hit;
  logic                   lo_hit;
  logic                   avg_restart;
  logic [ACC_W:0]         acc_sum;
  logic [ACC_W-1:0]       acc_base;
  logic [CNT_W-1:0]       cnt_nx;
  logic signed [CW-1:0]   d_rp;
  logic signed [CW-1:0]   err_full;
  logic [2:0]             stat;

  assign wr_go  = !AWREADY && !WREADY && !BVALID;
  assign wr_idx = awaddr_q[ADDR_W-1:2];
  assign rd_idx = ARADDR[ADDR_W-1:2];

  ////////////////////////////////////////////////////////////////////////////
  // bus write channel: address and data taken in either order
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      AWREADY  <= 1'b1;
      WREADY   <= 1'b1;
      BVALID   <= 1'b0;
      BRESP    <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else begin
      if (AWVALID && AWREADY) begin
        awaddr_q <= AWADDR;
        AWREADY  <= 1'b0;
      end
      if (WVALID && WREADY) begin
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
        WREADY  <= 1'b0;
      end
      if (wr_go) begin
        BVALID <= 1'b1;
        BRESP  <= mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read channel
  always_comb begin
    rd_word = '0;
    unique case (rd_idx)
      IDX_CONV_CTRL:      rd_word[7:0] = (8'(continuous_en_q) << CONTINUOUS_EN_BIT) | (8'(go_q) << GO_BIT);
      IDX_SAMPLE_CTRL:    rd_word[DOUBLE_SAMPLE_EN_BIT] = double_sample_en_q;
      IDX_COMPUTE_CTRL:   rd_word[7:0] = {prev_src_q, shift_q, accum_clear_q, mode_q};
      IDX_THRESHOLD_CTRL: rd_word[7:0] = {1'b0, err_sel_q, stop_on_q, tmd_q};
      IDX_COMPUTE_STATUS: rd_word[7:0] = {ov_q, up_flag_q, lo_flag_q, math_q, 1'b0, stat};
      IDX_SETPOINT:       rd_word[DW-1:0] = setpoint_q;
      IDX_UPPER_TH:       rd_word[DW-1:0] = uth_q;
      IDX_LOWER_TH:       rd_word[DW-1:0] = lth_q;
      IDX_REPEAT:         rd_word[CNT_W-1:0] = rpt_q;
      IDX_RESULT:         rd_word[DW-1:0] = result_q;
      IDX_PREV:           rd_word[DW-1:0] = prev_q;
      IDX_FILTER:         rd_word[DW-1:0] = filter_q;
      IDX_ERROR:          rd_word[DW-1:0] = err_q;
      IDX_ACCUM:          rd_word[ACC_W-1:0] = acc_q;
      IDX_COUNT:          rd_word[CNT_W-1:0] = cnt_q;
      default:            rd_word = '0;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= '0;
      RRESP   <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_word;
      RRESP   <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software control fields
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      continuous_en_q     <= 1'b0;
      double_sample_en_q     <= 1'b0;
      prev_src_q <= 1'b0;
      shift_q    <= '0;
      mode_q     <= MODE_BASIC;
      err_sel_q  <= ESEL_DIFF;
      stop_on_q  <= 1'b0;
      tmd_q      <= TMD_NEVER;
      setpoint_q <= '0;
      uth_q      <= '0;
      lth_q      <= '0;
      rpt_q      <= '0;
    end else if (wr_go) begin
      unique case (wr_idx)
        IDX_CONV_CTRL:   if (wstrb_q[0]) continuous_en_q <= wdata_q[CONTINUOUS_EN_BIT];
        IDX_SAMPLE_CTRL: if (wstrb_q[0]) double_sample_en_q <= wdata_q[DOUBLE_SAMPLE_EN_BIT];
        IDX_COMPUTE_CTRL: begin
          if (wstrb_q[0]) begin
            prev_src_q <= wdata_q[PSRC_BIT];
            shift_q    <= wdata_q[SHIFT_LSB +: 3];
            mode_q     <= wdata_q[MODE_LSB +: 3]; // R10
          end
        end
        IDX_THRESHOLD_CTRL: begin
          if (wstrb_q[0]) begin
            err_sel_q <= wdata_q[ESEL_LSB +: 3];
            stop_on_q <= wdata_q[STOP_BIT];
            tmd_q     <= wdata_q[TMD_LSB +: 3];
          end
        end
        IDX_SETPOINT: setpoint_q <= merge16(setpoint_q, wdata_q, wstrb_q);
        IDX_UPPER_TH: uth_q      <= merge16(uth_q, wdata_q, wstrb_q);
        IDX_LOWER_TH: lth_q      <= merge16(lth_q, wdata_q, wstrb_q);
        IDX_REPEAT:   if (wstrb_q[0]) rpt_q <= wdata_q[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_d = state_q;
    start1  = 1'b0;
    start2  = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (go_q) begin
          state_d = S_CONV1;
          start1  = 1'b1;
        end
      end
      S_CONV1: begin
        if (CONV_DONE && double_sample_en_q) begin
          state_d = S_CONV2; // R01
          start2  = 1'b1;
        end else if (CONV_DONE) begin
          state_d = S_ERROR_SEL_A;
        end
      end
      S_CONV2: if (CONV_DONE) state_d = S_ERROR_SEL_A;
      S_ERROR_SEL_A: begin
        if (mode_q == MODE_BURST && cnt_nx < rpt_q) begin
          state_d = S_CONV1;
          start1  = 1'b1;
        end else begin
          state_d = S_ERR; // R24
        end
      end
      S_ERR: state_d = S_THR;
      S_THR: begin
        if (retrig) begin
          state_d = S_CONV1; // R23
          start1  = 1'b1;
        end else begin
          state_d = S_IDLE;
        end
      end
    endcase
    // go cleared by software mid-trigger drops the trigger without compute
    if (!go_q && state_q != S_IDLE) begin
      state_d = S_IDLE;
      start1  = 1'b0;
      start2  = 1'b0;
    end
  end

  assign trig_start = start1 && (state_q == S_IDLE || state_q == S_THR);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q   <= S_IDLE;
      CONV_REQ  <= 1'b0;
      CONV_BUSY <= 1'b0;
    end else begin
      state_q   <= state_d;
      CONV_REQ  <= start1 || start2;
      CONV_BUSY <= state_d != S_IDLE;
    end
  end

  always_comb begin
    unique case (state_q)
      S_CONV1: stat = STAT_CONV1;
      S_CONV2: stat = STAT_CONV2;
      default: stat = STAT_IDLE;
    endcase
  end

  // go: a software write in the same cycle beats the hardware clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      go_q <= 1'b0;
    end else if (wr_go && wr_idx == IDX_CONV_CTRL && wstrb_q[0]) begin
      go_q <= wdata_q[GO_BIT];
    end else if (state_q == S_THR && !retrig) begin
      go_q <= 1'b0; // R17 R19 R23
    end else if (TRIGGER && state_q == S_IDLE) begin
      go_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result capture and previous-value copy at conversion start
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      result_q <= '0;
      prev_q   <= '0;
    end else begin
      if (start2) begin
        // first result lands in the same edge, so take it from the pins
        prev_q <= {{(DW-RES_W){1'b0}}, CONV_DATA}; // R01 R16
      end else if (start1) begin
        prev_q <= prev_src_q ? filter_q : result_q; // R02
      end
      if (CONV_DONE && (state_q == S_CONV1 || state_q == S_CONV2)) begin
        result_q <= {{(DW-RES_W){1'b0}}, CONV_DATA};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // computation modes
  assign avg_restart = mode_q == MODE_AVG && cnt_q >= rpt_q;
  assign cnt_nx      = avg_restart ? CNT_W'(1) :
                       (&cnt_q) ? cnt_q : cnt_q + CNT_W'(1);

  always_comb begin
    acc_base = avg_restart ? '0 : acc_q;
    unique case (mode_q)
      MODE_ACCUM, MODE_AVG, MODE_BURST:
        acc_sum = {1'b0, acc_base} + (ACC_W+1)'(result_q); // R04
      MODE_LPF:
        acc_sum = {1'b0, acc_q - (acc_q >> shift_q)} + (ACC_W+1)'(result_q); // R03
      default:
        acc_sum = {1'b0, acc_q}; // R05
    endcase
  end

  // clear command has priority; hardware drops it one cycle later
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      accum_clear_q <= 1'b0;
    end else if (wr_go && wr_idx == IDX_COMPUTE_CTRL && wstrb_q[0] &&
                 wdata_q[ACCUM_CLEAR_CMD_BIT]) begin
      accum_clear_q <= 1'b1; // R08
    end else if (accum_clear_q) begin
      accum_clear_q <= 1'b0; // R09
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      acc_q    <= '0;
      cnt_q    <= '0;
      filter_q <= '0;
    end else if (accum_clear_q) begin
      acc_q <= '0; // R08
      cnt_q <= '0;
    end else if (trig_start && mode_q == MODE_BURST) begin
      acc_q <= '0;
      cnt_q <= '0;
    end else if (state_q == S_ERROR_SEL_A && mode_q != MODE_BASIC && mode_q <= MODE_LPF) begin
      acc_q    <= acc_sum[ACC_W-1:0];
      cnt_q    <= cnt_nx;
      filter_q <= DW'(acc_sum[ACC_W-1:0] >> shift_q); // R03 R04
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error value, computed after the mode update
  assign d_rp = zx(result_q) - zx(prev_q); // R16

  always_comb begin
    unique case (err_sel_q)
      ESEL_DIFF:     err_full = d_rp; // R11
      ESEL_SETPT:    err_full = double_sample_en_q ? d_rp - sx(setpoint_q)
                                       : zx(result_q) - sx(setpoint_q); // R12
      ESEL_FILT:     err_full = double_sample_en_q ? d_rp - zx(filter_q)
                                       : zx(result_q) - zx(filter_q); // R13
      ESEL_PREV_FLT: err_full = zx(prev_q) - zx(filter_q); // R14
      ESEL_FLT_SET:  err_full = zx(filter_q) - sx(setpoint_q); // R15
      default:       err_full = '0;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      err_q <= '0;
    end else if (state_q == S_ERR) begin
      err_q <= err_full[DW-1:0]; // R24
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold test
  assign up_hit = err_q > uth_q;
  assign lo_hit = err_q < lth_q;

  always_comb begin
    unique case (tmd_q)
      TMD_NEVER:   hit = 1'b0; // R20
      TMD_BELOW:   hit = lo_hit; // R21
      TMD_NOT_LOW: hit = !lo_hit; // R21
      TMD_INSIDE:  hit = err_q > lth_q && !up_hit && err_q != uth_q; // R22
      TMD_OUTSIDE: hit = lo_hit || up_hit; // R22
      TMD_NOT_UP:  hit = !up_hit; // R21
      TMD_ABOVE:   hit = up_hit; // R21
      TMD_ALWAYS:  hit = 1'b1; // R20
    endcase
  end

  // stop setting only matters in continuous operation
  assign retrig = continuous_en_q && !(stop_on_q && hit); // R17 R18 R19

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      THRESH_EVENT <= 1'b0;
      up_flag_q    <= 1'b0;
      lo_flag_q    <= 1'b0;
    end else begin
      // a software abort written before the last cycle suppresses the event
      THRESH_EVENT <= state_q == S_THR && hit && go_q;
      if (state_q == S_THR) begin
        up_flag_q <= up_hit;
        lo_flag_q <= lo_hit;
      end
    end
  end

  // sticky status: hardware set wins over a software clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      math_q <= 1'b0;
      ov_q   <= 1'b0;
    end else begin
      if (state_q == S_ERROR_SEL_A) begin
        math_q <= 1'b1;
      end else if (wr_go && wr_idx == IDX_COMPUTE_STATUS && wstrb_q[0] &&
                   !wdata_q[MATH_BIT]) begin
        math_q <= 1'b0;
      end
      if (state_q == S_ERROR_SEL_A && acc_sum[ACC_W]) begin
        ov_q <= 1'b1;
      end else if (state_q == S_ERR &&
                   !(&err_full[CW-1:DW-1] || ~|err_full[CW-1:DW-1])) begin
        ov_q <= 1'b1;
      end else if (accum_clear_q) begin
        ov_q <= 1'b0; // R08
      end
    end
  end

endmodule : adcc_top
`default_nettype wire

// File: verification/adcc_chk.sv
`default_nettype none
module adcc_chk (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_B,
  // converter side
  input wire logic        CONV_REQ,
  input wire logic        CONV_BUSY,
  input wire logic        THRESH_EVENT,
  // register bus
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        RREADY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence rd_taken;
    ARVALID && ARREADY;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  req_pulse_a: assert property (CONV_REQ |=> !CONV_REQ)
    else $error("conversion request longer than one cycle");
  req_busy_a: assert property (CONV_REQ |-> CONV_BUSY)
    else $error("conversion request while idle");
  event_end_a: assert property (THRESH_EVENT |-> $past(CONV_BUSY))
    else $error("threshold event outside a trigger");
  event_once_a: assert property (THRESH_EVENT |=> !THRESH_EVENT)
    else $error("threshold event repeated");
  ////////////////////////////////////////////////////////////////////////////
  // answers must hold until the master takes them
  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  read_lat_a: assert property (rd_taken |=> RVALID)
    else $error("read answer late");
  write_lat_a: assert property (wr_taken |=> !BVALID ##1 BVALID)
    else $error("write answer not two cycles after take");
  write_refuse_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("new write accepted before response");
endmodule : adcc_chk

bind adcc_top adcc_chk u_chk (.*);
`default_nettype wire

// File: verification/tb.sv
`default_nettype none
module tb import adcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 0, RST_B = 0, TRIGGER = 0, CONV_DONE = 0;
  logic [11:0] CONV_DATA = '0, AWADDR = '0, ARADDR = '0;
  logic [31:0] WDATA = '0;
  logic [3:0]  WSTRB = '0;
  logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  wire logic   CONV_REQ, CONV_BUSY, THRESH_EVENT, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  wire logic [1:0]  BRESP, RRESP;
  wire logic [31:0] RDATA;
  int          num_errors = 0, checks_done = 0, cyc = 0, ev_cnt = 0, e0;
  logic [31:0] rv;
  logic [1:0]  rr;
  logic [7:0]  hit_mask [2] = '{8'hA4, 8'hB2};

  adcc_top dut (.*);

  always #5 CLK = ~CLK;
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (THRESH_EVENT === 1'b1) ev_cnt <= ev_cnt + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    logic a, w;
    a = 1;
    w = 1;
    AWADDR <= {i, 2'b00};
    WDATA <= d;
    WSTRB <= 4'hF;
    AWVALID <= 1;
    WVALID <= 1;
    BREADY <= 1;
    do begin
      @(posedge CLK);
      if (a && AWREADY === 1'b1) begin a = 0; AWVALID <= 0; end
      if (w && WREADY === 1'b1) begin w = 0; WVALID <= 0; end
    end while (BVALID !== 1'b1);
    rr = BRESP;
  endtask : wr

  task automatic rd(input logic [9:0] i, output logic [31:0] d, output logic [1:0] r);
    ARADDR <= {i, 2'b00};
    ARVALID <= 1;
    RREADY <= 1;
    do begin
      @(posedge CLK);
      if (ARREADY === 1'b1) ARVALID <= 0;
    end while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
  endtask : rd

  task automatic rc(input string n, input logic [9:0] i, input logic [15:0] e);
    rd(i, rv, rr);
    chk(n, rv[15:0], e);
  endtask : rc
  ////////////////////////////////////////////////////////////////////////////
  // converter answers three cycles after each request, never in the same cycle
  task automatic serve(input logic [11:0] d);
    do @(posedge CLK); while (CONV_REQ !== 1'b1);
    repeat (3) @(posedge CLK);
    CONV_DONE <= 1;
    CONV_DATA <= d;
    @(posedge CLK);
    CONV_DONE <= 0;
  endtask : serve

  task automatic go_pin();
    TRIGGER <= 1;
    @(posedge CLK);
    TRIGGER <= 0;
  endtask : go_pin

  task automatic idle();
    do @(posedge CLK); while (CONV_BUSY !== 1'b0);
    @(posedge CLK);
  endtask : idle

  task automatic shot(input logic [11:0] d);
    go_pin();
    serve(d);
    idle();
  endtask : shot
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge CLK);
    RST_B <= 1;
    rc("cmp_ctrl", IDX_COMPUTE_CTRL, 16'h0000);
    rc("thr_ctrl", IDX_THRESHOLD_CTRL, 16'h0000);
    rd(10'h3FF, rv, rr);
    chk("unmapped", 16'(rr), 16'(RESP_SLVERR));
    wr(IDX_THRESHOLD_CTRL, 8'h57);
    chk("bresp", 16'(rr), 16'(RESP_OKAY));
    rc("thr_rw", IDX_THRESHOLD_CTRL, 16'h0057);
    wr(IDX_THRESHOLD_CTRL, 8'h07);
    shot(12'h064);
    shot(12'h096);
    rc("prev", IDX_PREV, 16'h0064);
    rc("err_diff", IDX_ERROR, 16'h0032);
    wr(IDX_UPPER_TH, 16'h0032);
    wr(IDX_LOWER_TH, 16'h0028);
    // error sits on the upper, then below the lower threshold
    for (int p = 0; p < 2; p++) begin
      for (int t = 0; t < 8; t++) begin
        wr(IDX_THRESHOLD_CTRL, 32'h0000_0010 + t);
        e0 = ev_cnt;
        shot(p ? 12'h01E : 12'h032);
        chk("event", 16'(ev_cnt != e0), 16'(hit_mask[p][t]));
      end
    end
    rc("status", IDX_COMPUTE_STATUS, 16'h0030);
    wr(IDX_SAMPLE_CTRL, 8'h01);
    wr(IDX_SETPOINT, 16'h0005);
    wr(IDX_THRESHOLD_CTRL, 8'h17);
    go_pin();
    serve(12'h0C8);
    serve(12'h104);
    idle();
    rc("prev_dbl", IDX_PREV, 16'h00C8);
    rc("err_dbl", IDX_ERROR, 16'h0037);
    wr(IDX_SAMPLE_CTRL, 8'h00);
    wr(IDX_COMPUTE_CTRL, 8'h29);
    wr(IDX_SETPOINT, 16'h001E);
    shot(12'h064);
    shot(12'h0C8);
    rc("accum", IDX_ACCUM, 16'h012C);
    rc("count", IDX_COUNT, 16'h0002);
    rc("filter", IDX_FILTER, 16'h004B);
    wr(IDX_THRESHOLD_CTRL, 8'h57);
    shot(12'h064);
    rc("err_fs", IDX_ERROR, 16'h0046);
    wr(IDX_THRESHOLD_CTRL, 8'h47);
    shot(12'h064);
    rc("err_pf", IDX_ERROR, 16'hFFE7);
    wr(IDX_THRESHOLD_CTRL, 8'h27);
    shot(12'h0A0);
    rc("err_rf", IDX_ERROR, 16'hFFFB);
    wr(IDX_COMPUTE_CTRL, 8'hA1);
    shot(12'h000);
    rc("prev_flt", IDX_PREV, 16'h00A5);
    wr(IDX_COMPUTE_CTRL, 8'h29);
    rc("clr_bit", IDX_COMPUTE_CTRL, 16'h0021);
    rc("accum_clr", IDX_ACCUM, 16'h0000);
    rc("count_clr", IDX_COUNT, 16'h0000);
    wr(IDX_COMPUTE_CTRL, 8'h24);
    shot(12'h040);
    shot(12'h040);
    rc("lpf", IDX_FILTER, 16'h001C);
    wr(IDX_REPEAT, 8'h02);
    wr(IDX_COMPUTE_CTRL, 8'h13);
    go_pin();
    serve(12'h010);
    serve(12'h020);
    idle();
    rc("burst", IDX_FILTER, 16'h0018);
    wr(IDX_COMPUTE_CTRL, 8'h12);
    shot(12'h030);
    shot(12'h050);
    rc("avg", IDX_FILTER, 16'h0040);
    wr(IDX_THRESHOLD_CTRL, 8'h0F);
    wr(IDX_CONV_CTRL, 8'h40);
    shot(12'h010);
    rc("go_stop", IDX_CONV_CTRL, 16'h0040);
    wr(IDX_THRESHOLD_CTRL, 8'h07);
    go_pin();
    serve(12'h011);
    serve(12'h012);
    rc("go_run", IDX_CONV_CTRL, 16'h0041);
    wr(IDX_CONV_CTRL, 8'h40);
    idle();
    rc("go_sw", IDX_CONV_CTRL, 16'h0040);
    complete_run();
  end
endmodule : tb
`default_nettype wire
